// *** rtl/iee_regs.sv ***
// Interrupt edge-select, enable and request-flag register bank on APB.
// Assumes peripheral events are single-cycle pulses in the CLOCK domain.
//
// The implementer's own choice: the APB interface to the registers.
module iee_regs
	import iee_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [15:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [3:0] EXT_REQ_PIN,
	input wire logic [7:0] PIN_REQ_PIN,
	input wire logic [3:0] EXT_REQ_PIN_IS_IRQ,
	input wire logic [7:0] PIN_REQ_PIN_IS_IRQ,
	input wire logic TIMER_Y_EVENT_PIN,
	input wire logic TIMER_B_EVENT_PIN,
	input wire logic CONV_TRIGGER_PIN,
	input wire iee_periph_evt_t PERIPH_EVT,
	output iee_req_t REQ,
	output logic TIMER_Y_EVENT,
	output logic TIMER_B_EVENT,
	output logic CONV_TRIGGER
);
	logic [7:0] ext_req_edge_select_ff;
	logic [7:0] pin_req_edge_select_ff;
	logic [7:0] timer_ext_req_enable_ff;
	logic [7:0] periph_req_enable_ff;
	logic [7:0] pin_req_enable_ff;
	logic [7:0] timer_ext_req_flags_ff;
	logic [7:0] periph_req_flags_ff;
	logic [7:0] pin_req_flags_ff;
	logic [7:0] nxt_timer_ext_req_flags;
	logic [7:0] nxt_periph_req_flags;
	logic [7:0] nxt_pin_req_flags;
	logic [3:0] ext_hit;
	logic [7:0] pin_hit;
	logic [2:0] shared_hit;
	logic [7:0] te_set;
	logic [7:0] per_set;
	logic [7:0] pin_set;
	logic [7:0] rd_byte;
	logic hit_map;
	logic wr_access;
	logic wr_lane;
	logic [7:0] wd;

	assign wr_access = PSEL & PENABLE & PWRITE;
	assign wr_lane = PSTRB[0];
	assign wd = PWDATA[7:0];

	always_comb begin
		hit_map = 1'b1;
		unique case (PADDR)
			IEE_ADDR_EXT_EDGE: rd_byte = ext_req_edge_select_ff;
			IEE_ADDR_PIN_EDGE: rd_byte = pin_req_edge_select_ff;
			IEE_ADDR_TE_EN: rd_byte = timer_ext_req_enable_ff;
			IEE_ADDR_PER_EN: rd_byte = periph_req_enable_ff;
			IEE_ADDR_PIN_EN: rd_byte = pin_req_enable_ff;
			IEE_ADDR_TE_FLG: rd_byte = timer_ext_req_flags_ff;
			IEE_ADDR_PER_FLG: rd_byte = periph_req_flags_ff;
			IEE_ADDR_PIN_FLG: rd_byte = pin_req_flags_ff;
			default: begin
				rd_byte = 8'h00;
				hit_map = 1'b0;
			end
		endcase
	end

	// Edge detectors: 4 external pins, 8 request pins, 3 shared inputs
	genvar gi;
	generate
		for (gi = 0; gi < IEE_NUM_EXT; gi++) begin : g_ext
			iee_edge_det u_det (
				.clk(CLOCK),
				.rst_n(RESETN),
				.pin(EXT_REQ_PIN[gi]),
				.rise_sel(ext_req_edge_select_ff[gi]),
				.hit(ext_hit[gi])
			);
		end
		for (gi = 0; gi < IEE_NUM_PIN; gi++) begin : g_pin
			iee_edge_det u_det (
				.clk(CLOCK),
				.rst_n(RESETN),
				.pin(PIN_REQ_PIN[gi]),
				.rise_sel(pin_req_edge_select_ff[gi]),
				.hit(pin_hit[gi])
			);
		end
	endgenerate

	iee_edge_det u_ty (
		.clk(CLOCK),
		.rst_n(RESETN),
		.pin(TIMER_Y_EVENT_PIN),
		.rise_sel(pin_req_edge_select_ff[IEE_BIT_TY]),
		.hit(shared_hit[2])
	);
	iee_edge_det u_tb (
		.clk(CLOCK),
		.rst_n(RESETN),
		.pin(TIMER_B_EVENT_PIN),
		.rise_sel(pin_req_edge_select_ff[IEE_BIT_TB]),
		.hit(shared_hit[1])
	);
	iee_edge_det u_trg (
		.clk(CLOCK),
		.rst_n(RESETN),
		.pin(CONV_TRIGGER_PIN),
		.rise_sel(pin_req_edge_select_ff[IEE_BIT_TRG]),
		.hit(shared_hit[0])
	);

	// Edge-select registers
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			ext_req_edge_select_ff <= IEE_RST_EXT_EDGE;
			pin_req_edge_select_ff <= IEE_RST_PIN_EDGE;
		end else if (wr_access && wr_lane) begin
			if (PADDR == IEE_ADDR_EXT_EDGE)
				ext_req_edge_select_ff <= (wd & IEE_WMASK_EXT_EDGE)
					| (IEE_RST_EXT_EDGE & ~IEE_WMASK_EXT_EDGE);
			if (PADDR == IEE_ADDR_PIN_EDGE)
				pin_req_edge_select_ff <= wd;
		end
	end

	// Enable registers
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			timer_ext_req_enable_ff <= IEE_RST_TE_EN;
			periph_req_enable_ff <= IEE_RST_PER_EN;
			pin_req_enable_ff <= IEE_RST_PIN_EN;
		end else if (wr_access && wr_lane) begin
			if (PADDR == IEE_ADDR_TE_EN)
				timer_ext_req_enable_ff <= (wd & IEE_WMASK_TE)
					| (IEE_RST_TE_EN & ~IEE_WMASK_TE);
			if (PADDR == IEE_ADDR_PER_EN)
				periph_req_enable_ff <= wd & IEE_WMASK_PER;
			if (PADDR == IEE_ADDR_PIN_EN)
				pin_req_enable_ff <= wd;
		end
	end

	// Flag set sources; CPU mask plays no part here
	always_comb begin
		te_set = 8'h00;
		te_set[IEE_BIT_TB1] = PERIPH_EVT.timer_b1_ovf;
		te_set[IEE_BIT_TA] = PERIPH_EVT.timer_a_ovf;
		te_set[3:0] = ext_hit & EXT_REQ_PIN_IS_IRQ;
		per_set = 8'h00;
		per_set[IEE_BIT_DT] = PERIPH_EVT.direct_xfer;
		per_set[IEE_BIT_AD] = PERIPH_EVT.conv_done;
		per_set[IEE_BIT_S1] = PERIPH_EVT.serial1_done;
		pin_set = pin_hit & PIN_REQ_PIN_IS_IRQ;
	end

	// Set wins over a same-cycle clear; write of one leaves a flag alone
	always_comb begin
		nxt_timer_ext_req_flags = timer_ext_req_flags_ff;
		nxt_periph_req_flags = periph_req_flags_ff;
		nxt_pin_req_flags = pin_req_flags_ff;
		if (wr_access && wr_lane) begin
			if (PADDR == IEE_ADDR_TE_FLG)
				nxt_timer_ext_req_flags = timer_ext_req_flags_ff & (wd | ~IEE_WMASK_TE);
			if (PADDR == IEE_ADDR_PER_FLG)
				nxt_periph_req_flags = periph_req_flags_ff & (wd | ~IEE_WMASK_PER);
			if (PADDR == IEE_ADDR_PIN_FLG)
				nxt_pin_req_flags = pin_req_flags_ff & wd;
		end
		nxt_timer_ext_req_flags = nxt_timer_ext_req_flags | te_set;
		nxt_periph_req_flags = nxt_periph_req_flags | per_set;
		nxt_pin_req_flags = nxt_pin_req_flags | pin_set;
	end

	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			timer_ext_req_flags_ff <= IEE_RST_TE_FLG;
			periph_req_flags_ff <= IEE_RST_PER_FLG;
			pin_req_flags_ff <= IEE_RST_PIN_FLG;
		end else begin
			timer_ext_req_flags_ff <= nxt_timer_ext_req_flags;
			periph_req_flags_ff <= nxt_periph_req_flags;
			pin_req_flags_ff <= nxt_pin_req_flags;
		end
	end

	// Registered requests to priority logic, one cycle behind flags
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			REQ <= '0;
		end else begin
			REQ.timer_b1_ovf <= timer_ext_req_flags_ff[IEE_BIT_TB1]
				& timer_ext_req_enable_ff[IEE_BIT_TB1];
			REQ.timer_a_ovf <= timer_ext_req_flags_ff[IEE_BIT_TA]
				& timer_ext_req_enable_ff[IEE_BIT_TA];
			REQ.ext_req <= timer_ext_req_flags_ff[3:0] & timer_ext_req_enable_ff[3:0];
			REQ.direct_xfer <= periph_req_flags_ff[IEE_BIT_DT]
				& periph_req_enable_ff[IEE_BIT_DT];
			REQ.conv_done <= periph_req_flags_ff[IEE_BIT_AD]
				& periph_req_enable_ff[IEE_BIT_AD];
			REQ.serial1_done <= periph_req_flags_ff[IEE_BIT_S1]
				& periph_req_enable_ff[IEE_BIT_S1];
			REQ.pin_req <= pin_req_flags_ff & pin_req_enable_ff;
		end
	end

	// Shared edge events for timers and converter, registered
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			TIMER_Y_EVENT <= 1'b0;
			TIMER_B_EVENT <= 1'b0;
			CONV_TRIGGER <= 1'b0;
		end else begin
			TIMER_Y_EVENT <= shared_hit[2];
			TIMER_B_EVENT <= shared_hit[1];
			CONV_TRIGGER <= shared_hit[0];
		end
	end

	// APB: one wait-free access phase; read data registered at setup
	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			PRDATA <= 32'h0000_0000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= PSEL & ~PENABLE;
			PSLVERR <= PSEL & ~PENABLE & ~hit_map;
			if (PSEL && !PENABLE && !PWRITE)
				PRDATA <= {24'h00_0000, rd_byte};
		end
	end
endmodule // iee_regs

// *** common/iee_pkg.sv ***
// Constants, register map and carrier types for the interrupt edge/enable register bank.
// Assumes one 100 MHz clock domain and an APB master with 32-bit data.
// Functional notes
// - Eight byte registers at 0xFFF2 through 0xFFF9.
// - Flag writes clear on zero, never set.
// - Reset values 0x70, 0x00 for listed registers.
// - Edge-select one bits 7..4 read 0111, fixed.
// - Bits 3..0 pick external pin edge.
// - Second edge-select fully writable, resets zero.
// - Bit 7 edges pin 7 and timer Y.
// - Bit 6 edges pin 6 and timer B.
// - Bit 5 edges pin 5 and converter trigger.
// - Bits 4..0 edge their own pins.
// - First enable resets 0x10, bits 5,4 fixed.
// - Enable bit 7 gates timer B1 overflow.
// - Enable bit 6 gates timer A overflow.
// - Enable bits 3..0 gate external pins.
// - Second enable bits 5,3..0 read zero.
// - Enable bit 7 gates direct transfer.
// - Enable bit 6 gates converter completion.
// - Enable bit 4 gates serial channel 1.
// - Flags stay set until software clears.
// - Third enable gates pins 7..0.
// - Flags set regardless of CPU mask.
package iee_pkg;
	localparam logic [15:0] IEE_ADDR_EXT_EDGE = 16'hFFF2;
	localparam logic [15:0] IEE_ADDR_PIN_EDGE = 16'hFFF3;
	localparam logic [15:0] IEE_ADDR_TE_EN = 16'hFFF4;
	localparam logic [15:0] IEE_ADDR_PER_EN = 16'hFFF5;
	localparam logic [15:0] IEE_ADDR_PIN_EN = 16'hFFF6;
	localparam logic [15:0] IEE_ADDR_TE_FLG = 16'hFFF7;
	localparam logic [15:0] IEE_ADDR_PER_FLG = 16'hFFF8;
	localparam logic [15:0] IEE_ADDR_PIN_FLG = 16'hFFF9;
	localparam logic [7:0] IEE_RST_EXT_EDGE = 8'h70;
	localparam logic [7:0] IEE_RST_PIN_EDGE = 8'h00;
	localparam logic [7:0] IEE_RST_TE_EN = 8'h10;
	localparam logic [7:0] IEE_RST_PER_EN = 8'h00;
	localparam logic [7:0] IEE_RST_PIN_EN = 8'h00;
	localparam logic [7:0] IEE_RST_TE_FLG = 8'h10;
	localparam logic [7:0] IEE_RST_PER_FLG = 8'h00;
	localparam logic [7:0] IEE_RST_PIN_FLG = 8'h00;
	// Writable masks; fixed bits come from the reset value
	localparam logic [7:0] IEE_WMASK_EXT_EDGE = 8'h0F;
	localparam logic [7:0] IEE_WMASK_PIN_EDGE = 8'hFF;
	localparam logic [7:0] IEE_WMASK_TE = 8'hCF;
	localparam logic [7:0] IEE_WMASK_PER = 8'hD0;
	localparam logic [7:0] IEE_WMASK_PIN = 8'hFF;
	localparam int IEE_BIT_TB1 = 7;
	localparam int IEE_BIT_TA = 6;
	localparam int IEE_BIT_DT = 7;
	localparam int IEE_BIT_AD = 6;
	localparam int IEE_BIT_S1 = 4;
	localparam int IEE_BIT_TY = 7;
	localparam int IEE_BIT_TB = 6;
	localparam int IEE_BIT_TRG = 5;
	localparam int IEE_NUM_EXT = 4;
	localparam int IEE_NUM_PIN = 8;

	typedef struct packed {
		logic timer_b1_ovf;
		logic timer_a_ovf;
		logic direct_xfer;
		logic conv_done;
		logic serial1_done;
	} iee_periph_evt_t;

	typedef struct packed {
		logic timer_b1_ovf;
		logic timer_a_ovf;
		logic direct_xfer;
		logic conv_done;
		logic serial1_done;
		logic [3:0] ext_req;
		logic [7:0] pin_req;
	} iee_req_t;
endpackage

// *** rtl/iee_edge_det.sv ***
// One synchronised edge detector with a selectable sense.
// Assumes the pin is asynchronous to CLOCK; two-flop synchroniser first.
module iee_edge_det (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin,
	input wire logic rise_sel,
	output logic hit
);
	logic sync1_ff;
	logic sync2_ff;
	logic prev_ff;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
			prev_ff <= 1'b1;
		end else begin
			sync1_ff <= pin;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	// Current against previous system clock level
	assign hit = rise_sel ? (sync2_ff & ~prev_ff) : (~sync2_ff & prev_ff);
endmodule // iee_edge_det

// *** tb/iee_regs_checker.sv ***
// Port-level assertions for the interrupt edge/enable register bank.
// Assumes a single clock domain; bound onto every iee_regs instance.
module iee_regs_checker
	import iee_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [15:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire iee_req_t REQ,
	input wire logic TIMER_B_EVENT
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESETN);
	logic setup, rd, bad;
	assign setup = PSEL && !PENABLE;
	assign rd = PREADY && !PWRITE;
	assign bad = PADDR < IEE_ADDR_EXT_EDGE || PADDR > IEE_ADDR_PIN_FLG;
	a_ready_next: assert property (setup |=> PREADY)
		else $error("no ready after setup");
	a_ready_single: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	a_unmapped_err: assert property (setup && bad |=> PSLVERR && (PWRITE || PRDATA == 32'h0))
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (setup && !bad |=> !PSLVERR)
		else $error("mapped access refused");
	a_edge_fixed: assert property (rd && PADDR == IEE_ADDR_EXT_EDGE |-> PRDATA[7:4] == 4'h7)
		else $error("edge select fixed bits wrong");
	a_en1_fixed: assert property (rd && PADDR == IEE_ADDR_TE_EN |-> PRDATA[5:4] == 2'h1)
		else $error("first enable fixed bits wrong");
	a_en2_fixed: assert property (rd && PADDR == IEE_ADDR_PER_EN |-> {PRDATA[5], PRDATA[3:0]} == 5'h0)
		else $error("second enable reserved bits set");
	// Flag clears need a write, so with the bus quiet no request may drop
	a_req_holds: assert property (!PSEL && !$past(PSEL) && !$past(PSEL, 2) |=> &(REQ | ~$past(REQ)))
		else $error("request dropped without a write");
	a_pulse_single: assert property (TIMER_B_EVENT |=> !TIMER_B_EVENT)
		else $error("shared event longer than one cycle");
	c_unmapped: cover property (PREADY && PSLVERR);
	c_request: cover property (REQ != '0);
	c_shared: cover property (TIMER_B_EVENT);
endmodule // iee_regs_checker

bind iee_regs iee_regs_checker chk (.CLOCK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA,
	.PREADY, .PSLVERR, .REQ, .TIMER_B_EVENT);

// *** tb/iee_src_model.sv ***
// Stand-in for the request pins and the on-chip event sources.
// Assumes the bench calls its tasks; outputs move only just after a rising edge.
module iee_src_model
	import iee_pkg::*;
(
	input wire logic clk,
	output logic [3:0] ext_pin,
	output logic [7:0] pin_pin,
	output logic [2:0] shr_pin,
	output iee_periph_evt_t evt
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ext_pin = 4'hF;
		pin_pin = 8'hFF;
		shr_pin = 3'h7;
		evt = '0;
	end
	// All pins move together on one rising edge; the caller waits out the synchroniser
	task automatic level(input logic v);
		@(posedge clk);
		ext_pin <= {4{v}};
		pin_pin <= {8{v}};
		shr_pin <= {3{v}};
	endtask
	// Single-cycle pulses, as the real sources give
	task automatic pulse(input iee_periph_evt_t m);
		@(posedge clk);
		evt <= m;
		@(posedge clk);
		evt <= '0;
	endtask
endmodule // iee_src_model

// *** tb/iee_regs_bench.sv ***
// Self-checking bench for the interrupt edge/enable register bank.
// Assumes no wait states but always waits for PREADY under a bound.
module iee_regs_bench
	import iee_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, err, pready, pslverr, ty, tb, cv;
	logic [15:0] paddr = '0;
	logic [31:0] pwdata = '0, rdat, prdata;
	// External pin 2 and request pin 0 stay plain inputs, so their edges must set nothing
	logic [3:0] pstrb = 4'hF, ext_pin, eirq = 4'hB;
	logic [7:0] pin_pin, pirq = 8'hFE;
	logic [2:0] shr;
	logic [7:0] rv [8] = '{8'h70, 8'h00, 8'h10, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
	logic [7:0] fv [8] = '{8'h7F, 8'hFF, 8'hDF, 8'hD0, 8'hFF, 8'h10, 8'h00, 8'h00};
	iee_periph_evt_t evt;
	iee_req_t req;
	int n_errors = 0, checks = 0, nty = 0, ntb = 0, ncv = 0;
	iee_regs uut (.CLOCK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .EXT_REQ_PIN(ext_pin), .PIN_REQ_PIN(pin_pin),
		.EXT_REQ_PIN_IS_IRQ(eirq), .PIN_REQ_PIN_IS_IRQ(pirq), .TIMER_Y_EVENT_PIN(shr[2]),
		.TIMER_B_EVENT_PIN(shr[1]), .CONV_TRIGGER_PIN(shr[0]), .PERIPH_EVT(evt), .REQ(req),
		.TIMER_Y_EVENT(ty), .TIMER_B_EVENT(tb), .CONV_TRIGGER(cv));
	iee_src_model src (.clk(clk), .ext_pin(ext_pin), .pin_pin(pin_pin), .shr_pin(shr), .evt(evt));
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		nty += (ty === 1'h1);
		ntb += (tb === 1'h1);
		ncv += (cv === 1'h1);
	end
	task automatic fail(input string m);
		n_errors++;
		$display("CHECK FAILED at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
			fail($sformatf("got %h expected %h", g, e));
	endtask
	task automatic apb(input logic [15:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'h1;
		paddr <= a;
		pwr <= w;
		pwdata <= {24'h0, d};
		@(posedge clk);
		pen <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rdat = prdata;
		err = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
		if (n >= 20)
			fail("no ready");
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		apb(a, 1'h0, 8'h00);
		chk(rdat, {24'h0, e});
	endtask
	task automatic tally_and_finish();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#100us;
		fail("timeout");
		tally_and_finish();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		for (int i = 0; i < 8; i++) rd(IEE_ADDR_EXT_EDGE + 16'(i), rv[i]);
		$display("test reset values done");
		for (int i = 0; i < 8; i++) apb(IEE_ADDR_EXT_EDGE + 16'(i), 1'h1, 8'hFF);
		for (int i = 0; i < 8; i++) rd(IEE_ADDR_EXT_EDGE + 16'(i), fv[i]);
		pstrb <= 4'h0;
		apb(IEE_ADDR_PIN_EN, 1'h1, 8'h00);
		pstrb <= 4'hF;
		rd(IEE_ADDR_PIN_EN, 8'hFF);
		for (int i = 0; i < 8; i++) apb(IEE_ADDR_EXT_EDGE + 16'(i), 1'h1, 8'h00);
		for (int i = 0; i < 8; i++) rd(IEE_ADDR_EXT_EDGE + 16'(i), rv[i]);
		apb(16'hFFFA, 1'h0, 8'h00);
		chk({rdat[30:0], err}, 32'h1);
		apb(16'hFFF1, 1'h1, 8'hFF);
		chk(32'(err), 32'h1);
		$display("test register access done");
		apb(IEE_ADDR_EXT_EDGE, 1'h1, 8'h05);
		apb(IEE_ADDR_PIN_EDGE, 1'h1, 8'hA0);
		src.level(1'h0);
		repeat (8) @(posedge clk);
		rd(IEE_ADDR_TE_FLG, 8'h1A);
		rd(IEE_ADDR_PIN_FLG, 8'h5E);
		chk(32'(nty * 256 + ntb * 16 + ncv), 32'h010);
		src.level(1'h1);
		repeat (8) @(posedge clk);
		rd(IEE_ADDR_TE_FLG, 8'h1B);
		rd(IEE_ADDR_PIN_FLG, 8'hFE);
		chk(32'(nty * 256 + ntb * 16 + ncv), 32'h111);
		$display("test edge sensing done");
		src.pulse(5'h1F);
		repeat (4) @(posedge clk);
		rd(IEE_ADDR_TE_FLG, 8'hDB);
		rd(IEE_ADDR_PER_FLG, 8'hD0);
		chk(32'(req), 32'h0);
		apb(IEE_ADDR_TE_EN, 1'h1, 8'hCF);
		apb(IEE_ADDR_PER_EN, 1'h1, 8'hD0);
		apb(IEE_ADDR_PIN_EN, 1'h1, 8'h0F);
		repeat (4) @(posedge clk);
		chk(32'(req), 32'h1FB0E);
		apb(IEE_ADDR_TE_FLG, 1'h1, 8'h00);
		apb(IEE_ADDR_PER_FLG, 1'h1, 8'h00);
		apb(IEE_ADDR_PIN_FLG, 1'h1, 8'hF0);
		repeat (4) @(posedge clk);
		rd(IEE_ADDR_TE_FLG, 8'h10);
		rd(IEE_ADDR_PIN_FLG, 8'hF0);
		chk(32'(req), 32'h0);
		$display("test request gating done");
		tally_and_finish();
	end
endmodule // iee_regs_bench
